// File: logic/lcpu_cfg_upper.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RQ1: Byte eleven bit one enables end-of-carrier padding
// RQ2: Byte eleven bit two selects CRC stored
// RQ3: Byte eleven bit three retransmits on preamble collision
// RQ4: Byte eleven bit five accepts all multicast
// RQ5: Byte nine bits 0-2 set carrier filter
// RQ6: Byte nine bit three picks carrier source
// RQ7: Byte nine bits 4-6 set collision filter
// RQ8: Byte nine bit seven picks collision source; zero
// RQ9: Any reset restores every parameter default
// RQ10: Slot time is byte7[2:0] above byte6
// RQ11: Retry count is byte seven upper nibble
module lcpu_cfg_upper (
    input  wire logic       ref_clk_i,      // 20 MHz controller clock
    input  wire logic       rst_n_i,        // Hardware reset, async
    input  wire logic       soft_reset_i,   // Software reset pulse
    input  wire logic       cfg_wr_i,       // Parameter byte strobe
    input  wire logic [3:0] cfg_idx_i,      // Parameter byte index
    input  wire logic [7:0] cfg_data_i,     // Parameter byte value
    input  wire logic       crs_ext_i,      // External carrier sense
    input  wire logic       crs_int_i,      // Internal carrier sense
    input  wire logic       cdt_ext_i,      // External collision
    input  wire logic       cdt_int_i,      // Internal collision
    output logic [10:0]     slot_time_o,    // Slot time, bit times
    output logic [3:0]      retry_max_o,    // Retries on collision
    output logic [7:0]      line_opts_o,    // Byte eight as held
    output logic [7:0]      min_frame_len_o,// Minimum frame length
    output logic            preamble_to_carrier_o,
    output logic            pad_enable_flag_o,
    output logic            rx_fcs_to_memory_o,
    output logic            preamble_collision_retry_o,
    output logic            collision_by_src_match_o,
    output logic            accept_all_multicast_o,
    output logic [1:0]      monitor_mode_o,
    output logic            two_way_simultaneous_o,
    output logic            several_station_addrs_o,
    output logic            no_backoff_o,
    output logic            carrier_source_sel_o,
    output logic            collision_source_sel_o,
    output logic            carrier_sense_o, // Filtered carrier
    output logic            collision_o      // Filtered collision
);
    import lcpu_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] slot_low;     // Slot time low byte
        logic [7:0] retry_slot;   // Retries and slot high
        logic [7:0] line_crc;     // Line and CRC options
        logic [7:0] sense;        // Filter lengths and sources
        logic [7:0] min_len;      // Minimum frame length
        logic [7:0] rx_feat;      // Receive feature options
        logic [7:0] duplex;       // Duplex select
        logic [7:0] backoff;      // Backoff and multi address
        logic [2:0] crs_cnt;      // Carrier qualify counter
        logic [2:0] cdt_cnt;      // Collision qualify counter
        logic       crs_q;        // Qualified carrier
        logic       cdt_q;        // Qualified collision
    } lcpu_state_type;

    localparam lcpu_state_type LCPU_STATE_RST = '{
        slot_low:   LCPU_RST_SLOT_LOW,
        retry_slot: LCPU_RST_RETRY_SLOT,
        line_crc:   LCPU_RST_LINE_CRC,
        sense:      LCPU_RST_SENSE,
        min_len:    LCPU_RST_MIN_LEN,
        rx_feat:    LCPU_RST_RX_FEAT,
        duplex:     LCPU_RST_DUPLEX,
        backoff:    LCPU_RST_BACKOFF,
        crs_cnt:    3'h0,
        cdt_cnt:    3'h0,
        crs_q:      1'b0,
        cdt_q:      1'b0
    };

    lcpu_state_type st_r;         // Registered state
    lcpu_state_type st_nxt;       // Next state
    logic [1:0]     rst_sync_r;   // Reset release synchroniser
    logic           rst_n;        // Synchronised reset
    logic           crs_raw;      // Selected carrier input
    logic           cdt_raw;      // Selected collision input
    logic [2:0]     crs_len;      // Carrier filter length
    logic [2:0]     cdt_len;      // Collision filter length

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // Zero picks the external pin, one the internal path
    assign crs_raw = st_r.sense[LCPU_B9_CARRIER_SOURCE_SEL] ? crs_int_i
                                                 : crs_ext_i; // RQ6
    assign cdt_raw = st_r.sense[LCPU_B9_COLLISION_SOURCE_SEL] ? cdt_int_i
                                                 : cdt_ext_i; // RQ8
    // Filter lengths, counted in controller clock cycles
    assign crs_len = st_r.sense[LCPU_B9_CRS_LEN_LSB +: 3]; // RQ5
    assign cdt_len = st_r.sense[LCPU_B9_CDT_LEN_LSB +: 3]; // RQ7

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Carrier counts up while asserted, qualified at length
        if (!crs_raw) begin
            st_nxt.crs_cnt = 3'h0;
            st_nxt.crs_q   = 1'b0;
        end else if (st_r.crs_cnt >= crs_len) begin
            st_nxt.crs_q = 1'b1; // RQ5
        end else begin
            st_nxt.crs_cnt = st_r.crs_cnt + 3'h1;
        end
        // Collision qualified the same way with its own length
        if (!cdt_raw) begin
            st_nxt.cdt_cnt = 3'h0;
            st_nxt.cdt_q   = 1'b0;
        end else if (st_r.cdt_cnt >= cdt_len) begin
            st_nxt.cdt_q = 1'b1; // RQ7
        end else begin
            st_nxt.cdt_cnt = st_r.cdt_cnt + 3'h1;
        end
        // Parameter byte loads from the command unit
        if (cfg_wr_i) begin
            unique case (cfg_idx_i)
                LCPU_IDX_SLOT_LOW:   st_nxt.slot_low   = cfg_data_i;
                LCPU_IDX_RETRY_SLOT: st_nxt.retry_slot = cfg_data_i;
                LCPU_IDX_LINE_CRC:   st_nxt.line_crc   = cfg_data_i;
                LCPU_IDX_SENSE:      st_nxt.sense      = cfg_data_i;
                LCPU_IDX_MIN_LEN:    st_nxt.min_len    = cfg_data_i;
                LCPU_IDX_RX_FEAT:    st_nxt.rx_feat    = cfg_data_i;
                LCPU_IDX_DUPLEX:     st_nxt.duplex     = cfg_data_i;
                LCPU_IDX_BACKOFF:    st_nxt.backoff    = cfg_data_i;
                default: begin
                    // Bytes outside this block are ignored
                end
            endcase
        end
        // Software reset restores defaults and wins over a load
        if (soft_reset_i) begin
            st_nxt = LCPU_STATE_RST; // RQ9
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= LCPU_STATE_RST; // RQ9
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Decoded outputs
    // ------------------------------------------------------------
    assign slot_time_o = {st_r.retry_slot[LCPU_B7_SLOT_HI_LSB +: 3],
                          st_r.slot_low}; // RQ10
    assign retry_max_o = st_r.retry_slot[LCPU_B7_RETRY_LSB +: 4]; // RQ11
    assign line_opts_o     = st_r.line_crc;
    assign min_frame_len_o = st_r.min_len;
    assign preamble_to_carrier_o = st_r.rx_feat[LCPU_B11_PRE_CRS];
    assign pad_enable_flag_o     = st_r.rx_feat[LCPU_B11_PAD_EN]; // RQ1
    assign rx_fcs_to_memory_o    = st_r.rx_feat[LCPU_B11_FCS_MEM]; // RQ2
    assign preamble_collision_retry_o =
        st_r.rx_feat[LCPU_B11_PRE_RETRY]; // RQ3
    assign collision_by_src_match_o = st_r.rx_feat[LCPU_B11_SRC_MATCH];
    assign accept_all_multicast_o =
        st_r.rx_feat[LCPU_B11_ALL_MCAST]; // RQ4
    assign monitor_mode_o = st_r.rx_feat[LCPU_B11_MON_LSB +: 2];
    assign two_way_simultaneous_o  = st_r.duplex[LCPU_B12_TWO_WAY];
    assign several_station_addrs_o = st_r.backoff[LCPU_B13_MULTI_ADDR];
    assign no_backoff_o            = st_r.backoff[LCPU_B13_NO_BACKOFF];
    assign carrier_source_sel_o   = st_r.sense[LCPU_B9_CARRIER_SOURCE_SEL]; // RQ6
    assign collision_source_sel_o = st_r.sense[LCPU_B9_COLLISION_SOURCE_SEL]; // RQ8
    assign carrier_sense_o = st_r.crs_q;
    assign collision_o     = st_r.cdt_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sense_reset_zero: assert property ( // RQ8
        @(posedge ref_clk_i) $rose(rst_n) |-> st_r.sense == 8'h00)
        else $error("sense byte not zero after reset");
    a_soft_reset_dflt: assert property ( // RQ9
        @(posedge ref_clk_i) disable iff (!rst_n)
        soft_reset_i |=> (st_r.rx_feat == 8'hff
                          && st_r.retry_slot == 8'hf2
                          && st_r.min_len == 8'h40))
        else $error("defaults not restored");
    a_slot_concat: assert property ( // RQ10
        @(posedge ref_clk_i) disable iff (!rst_n)
        cfg_wr_i && !soft_reset_i && cfg_idx_i == 4'h6
        |=> slot_time_o[7:0] == $past(cfg_data_i))
        else $error("slot low byte not loaded");
    a_retry_load: assert property ( // RQ11
        @(posedge ref_clk_i) disable iff (!rst_n)
        cfg_wr_i && !soft_reset_i && cfg_idx_i == 4'h7
        |=> retry_max_o == $past(cfg_data_i[7:4])
            && slot_time_o[10:8] == $past(cfg_data_i[2:0]))
        else $error("byte seven fields wrong");
    a_rxfeat_load: assert property ( // RQ1
        @(posedge ref_clk_i) disable iff (!rst_n)
        cfg_wr_i && !soft_reset_i && cfg_idx_i == 4'hb
        |=> pad_enable_flag_o == $past(cfg_data_i[1])
            && rx_fcs_to_memory_o == $past(cfg_data_i[2])
            && preamble_collision_retry_o == $past(cfg_data_i[3])
            && accept_all_multicast_o == $past(cfg_data_i[5]))
        else $error("byte eleven flags wrong");
    a_crs_zero_filter: assert property ( // RQ5
        @(posedge ref_clk_i) disable iff (!rst_n || soft_reset_i)
        st_r.sense[2:0] == 3'h0 && crs_raw && $stable(st_r.sense)
        |=> carrier_sense_o)
        else $error("carrier not qualified at zero length");
    a_crs_drop: assert property ( // RQ6
        @(posedge ref_clk_i) disable iff (!rst_n)
        !crs_raw |=> !carrier_sense_o)
        else $error("carrier held without source");
    a_cdt_filter: assert property ( // RQ7
        @(posedge ref_clk_i) disable iff (!rst_n)
        $rose(collision_o) |-> $past(cdt_raw))
        else $error("collision without input");
    a_mcast_src: assert property ( // RQ4
        @(posedge ref_clk_i) disable iff (!rst_n)
        !(cfg_wr_i && cfg_idx_i == LCPU_IDX_RX_FEAT) && !soft_reset_i
        |=> $stable(accept_all_multicast_o))
        else $error("multicast flag changed without load");
    a_retx_flag: assert property ( // RQ3
        @(posedge ref_clk_i) disable iff (!rst_n)
        $rose(rst_n) |-> preamble_collision_retry_o)
        else $error("retry not enabled by default");
    a_fcs_flag: assert property ( // RQ2
        @(posedge ref_clk_i) disable iff (!rst_n)
        !cfg_wr_i && !soft_reset_i |=> $stable(rx_fcs_to_memory_o))
        else $error("fcs flag changed without load");

    // ------------------------------------------------------------
    // Checks: parameter holding and ignored bytes
    // ------------------------------------------------------------
    // Padding flag only moves on a byte eleven load or a reset
    a_pad_hold: assert property ( // RQ1
        @(posedge ref_clk_i) disable iff (!rst_n)
        !(cfg_wr_i && cfg_idx_i == LCPU_IDX_RX_FEAT) && !soft_reset_i
        |=> $stable(pad_enable_flag_o))
        else $error("pad flag changed without load");
    // Retry limit only moves on a byte seven load or a reset
    a_retry_hold: assert property ( // RQ11
        @(posedge ref_clk_i) disable iff (!rst_n)
        !(cfg_wr_i && cfg_idx_i == LCPU_IDX_RETRY_SLOT) && !soft_reset_i
        |=> $stable(retry_max_o))
        else $error("retry limit changed without load");
    // Indices outside this block leave slot time alone
    a_ignored_idx: assert property ( // RQ10
        @(posedge ref_clk_i) disable iff (!rst_n)
        cfg_wr_i && !soft_reset_i
        && (cfg_idx_i < LCPU_IDX_SLOT_LOW || cfg_idx_i > LCPU_IDX_BACKOFF)
        |=> $stable(slot_time_o) && $stable(retry_max_o))
        else $error("ignored index changed slot time");

    // ------------------------------------------------------------
    // Checks: filters and sources
    // ------------------------------------------------------------
    // Carrier rises only while the selected input is high
    a_crs_rise: assert property ( // RQ5
        @(posedge ref_clk_i) disable iff (!rst_n)
        $rose(carrier_sense_o) |-> $past(crs_raw))
        else $error("carrier without input");
    // Collision drops one edge after its input goes low
    a_cdt_drop: assert property ( // RQ7
        @(posedge ref_clk_i) disable iff (!rst_n)
        !cdt_raw |=> !collision_o)
        else $error("collision held without source");
    // Zero collision length qualifies on the next edge
    a_cdt_zero_filter: assert property ( // RQ7
        @(posedge ref_clk_i) disable iff (!rst_n || soft_reset_i)
        cdt_len == 3'h0 && cdt_raw && $stable(st_r.sense)
        |=> collision_o)
        else $error("collision not qualified at zero length");
    // Internal carrier source low keeps carrier off
    a_carrier_source_sel_int: assert property ( // RQ6
        @(posedge ref_clk_i) disable iff (!rst_n)
        carrier_source_sel_o && !crs_int_i |=> !carrier_sense_o)
        else $error("carrier from unselected internal path");
    // External carrier source low keeps carrier off
    a_carrier_source_sel_ext: assert property ( // RQ6
        @(posedge ref_clk_i) disable iff (!rst_n)
        !carrier_source_sel_o && !crs_ext_i |=> !carrier_sense_o)
        else $error("carrier from unselected external pin");
    // Internal collision source low keeps collision off
    a_collision_source_sel_int: assert property ( // RQ8
        @(posedge ref_clk_i) disable iff (!rst_n)
        collision_source_sel_o && !cdt_int_i |=> !collision_o)
        else $error("collision from unselected internal path");
    // External collision source low keeps collision off
    a_collision_source_sel_ext: assert property ( // RQ8
        @(posedge ref_clk_i) disable iff (!rst_n)
        !collision_source_sel_o && !cdt_ext_i |=> !collision_o)
        else $error("collision from unselected external pin");

    // ------------------------------------------------------------
    // Checks: reset defaults
    // ------------------------------------------------------------
    // Defaults stand at the edge on which reset lets go
    a_hw_reset_dflt: assert property ( // RQ9
        @(posedge ref_clk_i) disable iff (!rst_n)
        $rose(rst_n) |-> slot_time_o[7:0] == LCPU_RST_SLOT_LOW
            && slot_time_o[10:8] == LCPU_RST_RETRY_SLOT[2:0]
            && retry_max_o == LCPU_RST_RETRY_SLOT[7:4]
            && min_frame_len_o == LCPU_RST_MIN_LEN)
        else $error("defaults missing after reset");
endmodule
`default_nettype wire

// File: logic/lcpu_pkg.sv
package lcpu_pkg;
    // ------------------------------------------------------------
    // Parameter byte indices within the configure block
    // ------------------------------------------------------------
    localparam logic [3:0] LCPU_IDX_SLOT_LOW   = 4'h6;
    localparam logic [3:0] LCPU_IDX_RETRY_SLOT = 4'h7;
    localparam logic [3:0] LCPU_IDX_LINE_CRC   = 4'h8;
    localparam logic [3:0] LCPU_IDX_SENSE      = 4'h9;
    localparam logic [3:0] LCPU_IDX_MIN_LEN    = 4'ha;
    localparam logic [3:0] LCPU_IDX_RX_FEAT    = 4'hb;
    localparam logic [3:0] LCPU_IDX_DUPLEX     = 4'hc;
    localparam logic [3:0] LCPU_IDX_BACKOFF    = 4'hd;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LCPU_RST_SLOT_LOW   = 8'h00;
    localparam logic [7:0] LCPU_RST_RETRY_SLOT = 8'hf2;
    localparam logic [7:0] LCPU_RST_LINE_CRC   = 8'h00;
    localparam logic [7:0] LCPU_RST_SENSE      = 8'h00;
    localparam logic [7:0] LCPU_RST_MIN_LEN    = 8'h40;
    localparam logic [7:0] LCPU_RST_RX_FEAT    = 8'hff;
    localparam logic [7:0] LCPU_RST_DUPLEX     = 8'h00;
    localparam logic [7:0] LCPU_RST_BACKOFF    = 8'h3f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LCPU_B7_SLOT_HI_LSB = 0;
    localparam int LCPU_B7_RETRY_LSB   = 4;
    localparam int LCPU_B8_ACCEPT_ANY  = 0;
    localparam int LCPU_B8_BCAST_BLOCK = 1;
    localparam int LCPU_B8_MANCHESTER  = 2;
    localparam int LCPU_B8_TX_NO_CRS   = 3;
    localparam int LCPU_B8_NO_CRC_INS  = 4;
    localparam int LCPU_B8_CRC16       = 5;
    localparam int LCPU_B8_BIT_STUFF   = 6;
    localparam int LCPU_B8_PAD         = 7;
    localparam int LCPU_B9_CRS_LEN_LSB = 0;
    localparam int LCPU_B9_CARRIER_SOURCE_SEL     = 3;
    localparam int LCPU_B9_CDT_LEN_LSB = 4;
    localparam int LCPU_B9_COLLISION_SOURCE_SEL     = 7;
    localparam int LCPU_B11_PRE_CRS    = 0;
    localparam int LCPU_B11_PAD_EN     = 1;
    localparam int LCPU_B11_FCS_MEM    = 2;
    localparam int LCPU_B11_PRE_RETRY  = 3;
    localparam int LCPU_B11_SRC_MATCH  = 4;
    localparam int LCPU_B11_ALL_MCAST  = 5;
    localparam int LCPU_B11_MON_LSB    = 6;
    localparam int LCPU_B12_TWO_WAY    = 6;
    localparam int LCPU_B13_MULTI_ADDR = 6;
    localparam int LCPU_B13_NO_BACKOFF = 7;
endpackage

// File: bench/lcpu_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Host side: hands configure bytes to the command unit
// ------------------------------------------------------------
module lcpu_host_model (
    input  wire logic       ref_clk_i,  // Controller clock
    output var  logic       cfg_wr_o,   // Byte strobe
    output var  logic [3:0] cfg_idx_o,  // Byte index
    output var  logic [7:0] cfg_data_o  // Byte value
);
    // Idle bus at time zero
    initial begin
        cfg_wr_o   = 1'b0;
        cfg_idx_o  = 4'h0;
        cfg_data_o = 8'h00;
    end

    // One byte: strobe for one edge, then scramble the released bus
    task automatic put(input logic [3:0] idx, input logic [7:0] dat);
        @(negedge ref_clk_i);
        cfg_wr_o   = 1'b1;
        cfg_idx_o  = idx;
        cfg_data_o = dat;
        @(negedge ref_clk_i);
        cfg_wr_o   = 1'b0;
        cfg_idx_o  = ~idx;
        cfg_data_o = ~dat;
    endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import lcpu_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        ref_clk_i, rst_n_i, soft_reset_i;  // Clock and resets
    logic        crs_ext_i, crs_int_i;              // Carrier inputs
    logic        cdt_ext_i, cdt_int_i;              // Collision inputs
    wire logic   cfg_wr_i;                          // From host model
    wire logic [3:0] cfg_idx_i;                     // From host model
    wire logic [7:0] cfg_data_i;                    // From host model
    logic [10:0] slot;                              // Slot time
    logic [3:0]  retry;                             // Retry limit
    logic [7:0]  line_opts, min_len;                // Bytes 8 and 10
    logic [1:0]  mon;                               // Monitor field
    logic        pre_crs, pad, fcs, pre_ret, srcm;  // Byte 11 flags
    logic        mcast, two_way_simultaneous, multi, nobof;          // Misc flags
    logic        cs_sel, cd_sel, crs_o, cdt_o;      // Sense outputs
    logic [7:0]  b11;                               // Byte 11 as seen
    int          error_cnt = 0;                     // Mismatches
    int          n_tests = 0;                       // Comparisons
    assign b11 = {mon, mcast, srcm, pre_ret, fcs, pad, pre_crs};

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    lcpu_host_model host_i (.ref_clk_i(ref_clk_i), .cfg_wr_o(cfg_wr_i),
        .cfg_idx_o(cfg_idx_i), .cfg_data_o(cfg_data_i));
    lcpu_cfg_upper lcpu_cfg_upper_i (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i),
        .cfg_wr_i(cfg_wr_i), .cfg_idx_i(cfg_idx_i), .cfg_data_i(cfg_data_i),
        .crs_ext_i(crs_ext_i), .crs_int_i(crs_int_i), .cdt_ext_i(cdt_ext_i),
        .cdt_int_i(cdt_int_i), .slot_time_o(slot), .retry_max_o(retry),
        .line_opts_o(line_opts), .min_frame_len_o(min_len),
        .preamble_to_carrier_o(pre_crs), .pad_enable_flag_o(pad),
        .rx_fcs_to_memory_o(fcs), .preamble_collision_retry_o(pre_ret),
        .collision_by_src_match_o(srcm), .accept_all_multicast_o(mcast),
        .monitor_mode_o(mon), .two_way_simultaneous_o(two_way_simultaneous),
        .several_station_addrs_o(multi), .no_backoff_o(nobof),
        .carrier_source_sel_o(cs_sel), .collision_source_sel_o(cd_sel),
        .carrier_sense_o(crs_o), .collision_o(cdt_o));

    // ------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #(3000 * 50);
        error_cnt++;
        stop_test();
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [10:0] e, g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    // All parameters at their defaults
    task automatic chk_dflt();
        chk("slot", {LCPU_RST_RETRY_SLOT[2:0],LCPU_RST_SLOT_LOW}, slot);
        chk("retry", 11'h00f, 11'(retry));
        chk("line", 11'(LCPU_RST_LINE_CRC), 11'(line_opts));
        chk("minlen", 11'h040, 11'(min_len));
        chk("b11", 11'h0ff, 11'(b11));
        chk("flags", 11'h000, 11'({two_way_simultaneous, multi, nobof, cs_sel, cd_sel}));
    endtask
    // Rise latency of both filtered outputs, inputs raised by caller
    task automatic lat(input logic [3:0] e_cs, input logic [3:0] e_cd);
        logic [3:0] k, t_cs, t_cd;
        t_cs = 4'hf;
        t_cd = 4'hf;
        for (k = 4'h1; k < 4'hc; k++) begin
            @(posedge ref_clk_i);
            #1;
            if (crs_o === 1'b1 && t_cs == 4'hf) t_cs = k;
            if (cdt_o === 1'b1 && t_cd == 4'hf) t_cd = k;
        end
        chk("crs_lat", 11'(e_cs), 11'(t_cs));
        chk("cdt_lat", 11'(e_cd), 11'(t_cd));
    endtask
    task automatic hw_reset();
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        repeat (20) @(negedge ref_clk_i);
        chk_dflt();
        rst_n_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk_dflt();
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {soft_reset_i, crs_ext_i, crs_int_i, cdt_ext_i, cdt_int_i} = 5'h00;
        rst_n_i = 1'b0;
        #5;
        hw_reset();
        $display("test reset_defaults done");
        // Slot time and retries, then ignored indices
        host_i.put(LCPU_IDX_SLOT_LOW, 8'h5a);
        host_i.put(LCPU_IDX_RETRY_SLOT, 8'h35);
        host_i.put(4'h5, 8'h77);
        host_i.put(4'he, 8'h77);
        chk("slot", 11'h55a, slot);
        chk("retry", 11'h003, 11'(retry));
        $display("test slot_retry done");
        host_i.put(LCPU_IDX_LINE_CRC, 8'ha5);
        host_i.put(LCPU_IDX_MIN_LEN, 8'h3c);
        host_i.put(LCPU_IDX_DUPLEX, 8'h40);
        host_i.put(LCPU_IDX_BACKOFF, 8'hc0);
        chk("line", 11'h0a5, 11'(line_opts));
        chk("minlen", 11'h03c, 11'(min_len));
        chk("b12_13", 11'h007, 11'({two_way_simultaneous, multi, nobof}));
        // Each byte 11 bit alone
        for (int i = 0; i < 8; i++) begin
            host_i.put(LCPU_IDX_RX_FEAT, 8'h01 << i);
            chk("b11", 11'h001 << i, 11'(b11));
        end
        $display("test option_bits done");
        // Internal sources, carrier length 3, collision length 5
        host_i.put(LCPU_IDX_SENSE, 8'hdb);
        chk("srcs", 11'h003, 11'({cs_sel, cd_sel}));
        {crs_ext_i, cdt_ext_i} = 2'b11;
        repeat (8) @(posedge ref_clk_i);
        #1;
        chk("ext_ignored", 11'h000, 11'({crs_o, cdt_o}));
        @(negedge ref_clk_i);
        {crs_ext_i, cdt_ext_i, crs_int_i, cdt_int_i} = 4'h3;
        lat(4'h4, 4'h6);
        @(negedge ref_clk_i);
        {crs_int_i, cdt_int_i} = 2'b00;
        @(posedge ref_clk_i);
        #1;
        chk("drop", 11'h000, 11'({crs_o, cdt_o}));
        $display("test filters done");
        // Soft reset beats a write on the same edge
        fork
            host_i.put(LCPU_IDX_SLOT_LOW, 8'h11);
            begin
                @(negedge ref_clk_i);
                soft_reset_i = 1'b1;
                @(negedge ref_clk_i);
                soft_reset_i = 1'b0;
            end
        join
        chk_dflt();
        // Default external sources with zero length
        {crs_ext_i, cdt_ext_i} = 2'b11;
        lat(4'h1, 4'h1);
        @(negedge ref_clk_i);
        {crs_ext_i, cdt_ext_i} = 2'b00;
        @(posedge ref_clk_i);
        #1;
        chk("ext_drop", 11'h000, 11'({crs_o, cdt_o}));
        host_i.put(LCPU_IDX_RX_FEAT, 8'h00);
        hw_reset();
        $display("test resets done");
        stop_test();
    end
endmodule
`default_nettype wire
